// *** sdcs_chk.sv ***
// concurrent checks on the command interface between issuer and memory
`default_nettype none
module sdcs_chk (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic dq_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cmd;
    logic nop;
    logic [7:0] since_rd_ff;
    assign cmd = {cs_n, ras_n, cas_n, we_n};
    // deselect is a no-operation whatever the strobes show
    assign nop = cs_n | (cmd == sdcs_pkg::CMD_NOP);
    // counts enabled clocks only, since suspend freezes a burst
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            since_rd_ff <= 8'hff;
        end else if (cke && cmd == sdcs_pkg::CMD_READ) begin
            since_rd_ff <= 8'h00;
        end else if (cke && since_rd_ff != 8'hff) begin
            since_rd_ff <= since_rd_ff + 8'h01;
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);
    sequence s_read;
        cke && cmd == sdcs_pkg::CMD_READ;
    endsequence
    sequence s_burst;
        cke && (cmd == sdcs_pkg::CMD_READ || cmd == sdcs_pkg::CMD_WRITE);
    endsequence
    a_read_latency: assert property (s_read ##1 cke [*2] |-> ##[0:2] dq_oe)
        else $error("read data enable late");
    a_oe_window: assert property (dq_oe |-> since_rd_ff inside {[8'h01:8'h08]})
        else $error("read data enable without a read");
    a_burst_quiet: assert property (s_burst |=> nop [*4])
        else $error("command during a burst");
    a_act_wait: assert property (cmd == sdcs_pkg::CMD_ACT |=> nop)
        else $error("command while a row opens");
    a_refresh_quiet: assert property (cmd == sdcs_pkg::CMD_REF |=> nop [*3])
        else $error("command during refresh");
    a_mode_quiet: assert property (cmd == sdcs_pkg::CMD_MRS |=> nop [*2])
        else $error("command during mode access");
    a_lowpower_entry: assert property ($fell(cke) |-> nop || cmd == sdcs_pkg::CMD_REF)
        else $error("clock enable dropped with a command");
    a_exit_gap: assert property ($rose(cke) |=> nop)
        else $error("command right after clock enable rose");
endmodule : sdcs_chk
`default_nettype wire

// *** sdcs_ctl.sv ***
// command issuer end: turns single requests into legally spaced commands
`default_nettype none
module sdcs_ctl (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic i_req_valid,
    output logic o_req_ready,
    input wire logic [3:0] i_req_cmd,
    input wire logic i_req_cke,
    input wire logic [sdcs_pkg::BANK_W-1:0] i_req_ba,
    input wire logic [sdcs_pkg::ADDR_W-1:0] i_req_addr,
    input wire logic [sdcs_pkg::DATA_W-1:0] i_req_wdata,
    output logic [sdcs_pkg::DATA_W-1:0] o_rdata,
    output logic o_rdata_valid,
    sdcs_if.ctl bus
);
    logic [3:0] cmd_ff;
    logic cke_ff;
    logic [sdcs_pkg::BANK_W-1:0] ba_ff;
    logic [sdcs_pkg::ADDR_W-1:0] addr_ff;
    logic [sdcs_pkg::DATA_W-1:0] wdata_ff;
    logic [sdcs_pkg::CNT_W-1:0] gap_ff;
    logic [sdcs_pkg::CNT_W-1:0] nxt_gap;
    logic [sdcs_pkg::DATA_W-1:0] rdata_ff;
    logic rvalid_ff;
    logic take;

    // only nops go out while a gap runs, which covers the idle-only waits
    assign o_req_ready = (gap_ff == '0);
    assign take = i_req_valid && o_req_ready && i_clk_en;

    always_comb begin
        nxt_gap = '0;
        unique case (i_req_cmd)
            sdcs_pkg::CMD_ACT: nxt_gap = sdcs_pkg::RCD_CYC;
            sdcs_pkg::CMD_REF: nxt_gap = sdcs_pkg::RFC_CYC;
            sdcs_pkg::CMD_MRS: nxt_gap = sdcs_pkg::MRS_CYC;
            sdcs_pkg::CMD_PRE: nxt_gap = sdcs_pkg::RPL_CYC;
            // a write burst holds off every following command for BURST_LEN clocks
            sdcs_pkg::CMD_WRITE: nxt_gap = sdcs_pkg::BURST_LEN;
            sdcs_pkg::CMD_READ: nxt_gap = sdcs_pkg::BURST_LEN;
            default: nxt_gap = '0;
        endcase
        // a raised cke after low power gets a one-clock pause
        if (!cke_ff && i_req_cke) begin
            nxt_gap = 8'h01;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            cmd_ff <= sdcs_pkg::CMD_NOP;
            cke_ff <= 1'b1;
            ba_ff <= '0;
            addr_ff <= '0;
            wdata_ff <= '0;
            gap_ff <= '0;
        end else if (i_clk_en) begin
            if (take) begin
                cmd_ff <= i_req_cmd;
                cke_ff <= i_req_cke;
                ba_ff <= i_req_ba;
                addr_ff <= i_req_addr;
                wdata_ff <= i_req_wdata;
                gap_ff <= nxt_gap;
            end else begin
                cmd_ff <= sdcs_pkg::CMD_NOP;
                if (gap_ff != '0) begin
                    gap_ff <= gap_ff - 8'h01;
                end
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_ff <= '0;
            rvalid_ff <= 1'b0;
        end else if (i_clk_en) begin
            rvalid_ff <= bus.dq_oe;
            if (bus.dq_oe) begin
                rdata_ff <= bus.dq_from_mem;
            end
        end
    end

    assign bus.cke = cke_ff;
    assign {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n} = cmd_ff;
    assign bus.ba = ba_ff;
    assign bus.addr = addr_ff;
    assign bus.dq_to_mem = wdata_ff;
    assign o_rdata = rdata_ff;
    assign o_rdata_valid = rvalid_ff;
endmodule : sdcs_ctl
`default_nettype wire

// *** sdcs_if.sv ***
// interface joining the command issuer and the sdram command state machine
`default_nettype none
interface sdcs_if;
    logic cke;
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic [sdcs_pkg::BANK_W-1:0] ba;
    logic [sdcs_pkg::ADDR_W-1:0] addr;
    logic [sdcs_pkg::DATA_W-1:0] dq_to_mem;
    logic [sdcs_pkg::DATA_W-1:0] dq_from_mem;
    logic dq_oe;
    modport mem (input cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_to_mem,
        output dq_from_mem, dq_oe);
    modport ctl (output cke, cs_n, ras_n, cas_n, we_n, ba, addr, dq_to_mem,
        input dq_from_mem, dq_oe);
endinterface : sdcs_if
`default_nettype wire

// *** sdcs_mem.sv ***
// Function
// - idle plus activate opens row, latches row
// - idle refresh encoding starts auto or self refresh
// - refresh and mode access need all banks idle
// - active read latches column, bursts, takes precharge bit
// - active write latches column, bursts, takes precharge bit
// - nop during burst runs to end, active
// - burst stop ends burst, bank stays active
// - new read or write restarts the burst
// - precharge in read ends burst, read timing
// - precharge in write ends burst, recovery timing
// - controller honours contention, turnaround, write recovery
// - auto precharge burst accepts only nop
// - auto precharge done, idle after precharge time
// - activating accepts nop, active after delay
// - refreshing accepts nop, idle after cycle time
// - mode access accepts nop, idle two clocks
// - self refresh held low, exit after cycle
// - cke rise out of low power asynchronous
// - controller waits one clock after power-down exit
// - low power entered only from all idle
// - elsewhere cke low suspends clock next cycle
// - illegal command may act on named bank
// - read data after programmed column latency; here fixed at CAS_LAT, mode access does not set it
`default_nettype none
module sdcs_mem (
    input wire logic i_clock,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    output logic [sdcs_pkg::NUM_BANKS-1:0] o_bank_active,
    output logic o_all_idle,
    output logic o_self_refresh,
    output logic o_power_down,
    output logic o_suspend,
    output logic o_illegal,
    output logic o_write_strobe,
    output logic [sdcs_pkg::BANK_W-1:0] o_write_bank,
    output logic [sdcs_pkg::COL_W-1:0] o_write_col,
    output logic [sdcs_pkg::DATA_W-1:0] o_write_data,
    sdcs_if.mem bus
);
    localparam int unsigned NB = sdcs_pkg::NUM_BANKS;
    logic [3:0] cmd;
    logic cke_q_ff, cke_wake_ff, wake_seen_ff;
    logic run, all_idle;
    logic [NB-1:0] bank_idle, bank_ill;
    sdcs_pkg::sdcs_dev_e dev_ff;
    logic [sdcs_pkg::CNT_W-1:0] dev_cnt_ff;
    logic [sdcs_pkg::CAS_LAT-1:0] rd_pipe_ff;
    logic [NB-1:0] rd_beat, wr_beat;
    logic [NB-1:0][sdcs_pkg::COL_W-1:0] bank_col;
    logic [sdcs_pkg::DATA_W-1:0] dq_ff, row_mix;

    assign cmd = {bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n};
    // cke rise toggles a flag without the clock; a clocked copy marks it seen
    always_ff @(posedge bus.cke or negedge i_resetn) begin
        if (!i_resetn) begin
            cke_wake_ff <= 1'b0;
        end else begin
            cke_wake_ff <= !cke_wake_ff;
        end
    end

    // banks only see commands while the device runs normally with cke high
    assign run = (dev_ff == sdcs_pkg::SDCS_DEV_NORMAL) && cke_q_ff && bus.cke;
    assign all_idle = &bank_idle;

    generate
        for (genvar gb = 0; gb < NB; gb++) begin : g_bank
            sdcs_pkg::sdcs_bank_e st_ff;
            logic ap_ff;
            logic [sdcs_pkg::CNT_W-1:0] cnt_ff;
            logic [sdcs_pkg::ADDR_W-1:0] row_ff;
            logic [sdcs_pkg::COL_W-1:0] col_ff;
            logic sel, ill;
            // each bank acts only on commands naming it, except a precharge with the precharge bit set, which reaches every active, read or write bank
            assign sel = (bus.ba == sdcs_pkg::BANK_W'(gb));
            assign bank_idle[gb] = (st_ff == sdcs_pkg::SDCS_IDLE);
            assign rd_beat[gb] = (st_ff == sdcs_pkg::SDCS_READ)
                || (st_ff == sdcs_pkg::SDCS_READ_AP);
            assign wr_beat[gb] = ((st_ff == sdcs_pkg::SDCS_WRITE)
                || (st_ff == sdcs_pkg::SDCS_WRITE_AP)) && (cnt_ff != '0);
            assign bank_col[gb] = col_ff;
            assign o_bank_active[gb] = !bank_idle[gb];
            always_comb begin
                ill = 1'b0;
                if (run && sel && cmd != sdcs_pkg::CMD_NOP && !bus.cs_n) begin
                    unique case (st_ff)
                        sdcs_pkg::SDCS_READ_AP, sdcs_pkg::SDCS_WRITE_AP,
                        sdcs_pkg::SDCS_ACTIVATING: ill = 1'b1;
                        sdcs_pkg::SDCS_ACTIVE: ill = (cmd == sdcs_pkg::CMD_ACT);
                        sdcs_pkg::SDCS_IDLE: ill = (cmd == sdcs_pkg::CMD_READ)
                            || (cmd == sdcs_pkg::CMD_WRITE);
                        default: ill = (cmd == sdcs_pkg::CMD_ACT);
                    endcase
                end
            end
            assign bank_ill[gb] = ill;
            always_ff @(posedge i_clock or negedge i_resetn) begin
                if (!i_resetn) begin
                    st_ff <= sdcs_pkg::SDCS_IDLE;
                    ap_ff <= 1'b0;
                    cnt_ff <= '0;
                    row_ff <= '0;
                    col_ff <= '0;
                end else if (i_clk_en && run) begin
                    if (cnt_ff != '0) begin
                        cnt_ff <= cnt_ff - 8'h01;
                    end
                    unique case (st_ff)
                        sdcs_pkg::SDCS_IDLE: begin
                            if (sel && cmd == sdcs_pkg::CMD_ACT) begin
                                st_ff <= sdcs_pkg::SDCS_ACTIVATING;
                                row_ff <= bus.addr;
                                cnt_ff <= sdcs_pkg::RCD_CYC - 8'h01;
                            end
                        end
                        sdcs_pkg::SDCS_ACTIVATING: begin
                            if (cnt_ff == '0) begin
                                st_ff <= sdcs_pkg::SDCS_ACTIVE;
                            end
                        end
                        sdcs_pkg::SDCS_READ_AP, sdcs_pkg::SDCS_WRITE_AP: begin
                            // only nops reach here; burst end starts the precharge
                            if (cnt_ff == '0) begin
                                st_ff <= sdcs_pkg::SDCS_PRECHARGING;
                                cnt_ff <= (st_ff == sdcs_pkg::SDCS_WRITE_AP)
                                    ? sdcs_pkg::RPL_CYC : sdcs_pkg::RP_CYC;
                            end else begin
                                col_ff <= col_ff + 10'h001;
                            end
                        end
                        sdcs_pkg::SDCS_PRECHARGING: begin
                            if (cnt_ff == '0 || cnt_ff == 8'h01) begin
                                st_ff <= sdcs_pkg::SDCS_IDLE;
                            end
                        end
                        default: begin
                            // row active, read or write burst
                            if (sel && (cmd == sdcs_pkg::CMD_READ
                                    || cmd == sdcs_pkg::CMD_WRITE)) begin
                                ap_ff <= bus.addr[sdcs_pkg::AP_BIT];
                                col_ff <= bus.addr[sdcs_pkg::COL_W-1:0];
                                cnt_ff <= sdcs_pkg::BURST_LEN - 8'h01;
                                if (cmd == sdcs_pkg::CMD_READ) begin
                                    st_ff <= bus.addr[sdcs_pkg::AP_BIT]
                                        ? sdcs_pkg::SDCS_READ_AP : sdcs_pkg::SDCS_READ;
                                end else begin
                                    st_ff <= bus.addr[sdcs_pkg::AP_BIT]
                                        ? sdcs_pkg::SDCS_WRITE_AP : sdcs_pkg::SDCS_WRITE;
                                end
                            end else if ((sel || bus.addr[sdcs_pkg::AP_BIT])
                                    && cmd == sdcs_pkg::CMD_PRE) begin
                                st_ff <= sdcs_pkg::SDCS_PRECHARGING;
                                cnt_ff <= (st_ff == sdcs_pkg::SDCS_WRITE)
                                    ? sdcs_pkg::RPL_CYC : sdcs_pkg::RP_CYC;
                            end else if (st_ff != sdcs_pkg::SDCS_ACTIVE
                                    && sel && cmd == sdcs_pkg::CMD_STOP) begin
                                st_ff <= sdcs_pkg::SDCS_ACTIVE;
                            end else if (st_ff != sdcs_pkg::SDCS_ACTIVE) begin
                                if (cnt_ff == '0) begin
                                    st_ff <= sdcs_pkg::SDCS_ACTIVE;
                                end else begin
                                    col_ff <= col_ff + 10'h001;
                                end
                            end
                        end
                    endcase
                end
            end
        end
    endgenerate

    // device-wide modes; refresh and mode access ignored unless all idle
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            dev_ff <= sdcs_pkg::SDCS_DEV_NORMAL;
            dev_cnt_ff <= '0;
            cke_q_ff <= 1'b1;
            wake_seen_ff <= 1'b0;
        end else if (i_clk_en) begin
            cke_q_ff <= bus.cke;
            wake_seen_ff <= cke_wake_ff;
            unique case (dev_ff)
                sdcs_pkg::SDCS_DEV_NORMAL: begin
                    if (cke_q_ff && !bus.cke) begin
                        if (all_idle && cmd == sdcs_pkg::CMD_REF) begin
                            dev_ff <= sdcs_pkg::SDCS_DEV_SELF;
                        end else if (all_idle && (bus.cs_n || cmd == sdcs_pkg::CMD_NOP)) begin
                            dev_ff <= sdcs_pkg::SDCS_DEV_POWERDOWN;
                        end else begin
                            dev_ff <= sdcs_pkg::SDCS_DEV_SUSPEND;
                        end
                    end else if (run && all_idle && cmd == sdcs_pkg::CMD_REF) begin
                        dev_ff <= sdcs_pkg::SDCS_DEV_REFRESH;
                        dev_cnt_ff <= sdcs_pkg::RFC_CYC - 8'h01;
                    end else if (run && all_idle && cmd == sdcs_pkg::CMD_MRS) begin
                        dev_ff <= sdcs_pkg::SDCS_DEV_MODE;
                        dev_cnt_ff <= sdcs_pkg::MRS_CYC - 8'h01;
                    end
                end
                sdcs_pkg::SDCS_DEV_REFRESH, sdcs_pkg::SDCS_DEV_MODE: begin
                    if (dev_cnt_ff <= 8'h01) begin
                        dev_ff <= sdcs_pkg::SDCS_DEV_NORMAL;
                    end
                    dev_cnt_ff <= dev_cnt_ff - 8'h01;
                end
                sdcs_pkg::SDCS_DEV_SELF: begin
                    // held low keeps refreshing; the async flag marks the exit
                    if ((cke_wake_ff != wake_seen_ff) && bus.cke) begin
                        dev_ff <= sdcs_pkg::SDCS_DEV_REFRESH;
                        dev_cnt_ff <= sdcs_pkg::RFC_CYC;
                    end
                end
                sdcs_pkg::SDCS_DEV_POWERDOWN: begin
                    if ((cke_wake_ff != wake_seen_ff) && bus.cke) begin
                        dev_ff <= sdcs_pkg::SDCS_DEV_NORMAL;
                    end
                end
                sdcs_pkg::SDCS_DEV_SUSPEND: begin
                    if (bus.cke) begin
                        dev_ff <= sdcs_pkg::SDCS_DEV_NORMAL;
                    end
                end
                default: dev_ff <= sdcs_pkg::SDCS_DEV_NORMAL;
            endcase
        end
    end

    // read data pipe: bursting bank drives data after the column latency
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_pipe_ff <= '0;
            dq_ff <= '0;
        end else if (i_clk_en && run) begin
            rd_pipe_ff <= {rd_pipe_ff[sdcs_pkg::CAS_LAT-2:0], |rd_beat};
            dq_ff <= row_mix;
        end
    end
    // no array is modelled; read data is a column-derived pattern
    always_comb begin
        row_mix = '0;
        for (int i = 0; i < NB; i++) begin
            if (rd_beat[i]) begin
                row_mix = sdcs_pkg::DATA_W'({bank_col[i], 2'(i)});
            end
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            o_write_strobe <= 1'b0;
            o_write_bank <= '0;
            o_write_col <= '0;
            o_write_data <= '0;
        end else if (i_clk_en) begin
            o_write_strobe <= run && (cmd == sdcs_pkg::CMD_WRITE || |wr_beat);
            o_write_bank <= bus.ba;
            o_write_col <= bus.addr[sdcs_pkg::COL_W-1:0];
            o_write_data <= bus.dq_to_mem;
        end
    end

    assign o_illegal = (|bank_ill) || (run && !all_idle
        && (cmd == sdcs_pkg::CMD_REF || cmd == sdcs_pkg::CMD_MRS));
    assign o_all_idle = all_idle;
    assign o_self_refresh = (dev_ff == sdcs_pkg::SDCS_DEV_SELF);
    assign o_power_down = (dev_ff == sdcs_pkg::SDCS_DEV_POWERDOWN);
    assign o_suspend = (dev_ff == sdcs_pkg::SDCS_DEV_SUSPEND);
    assign bus.dq_from_mem = dq_ff;
    assign bus.dq_oe = rd_pipe_ff[sdcs_pkg::CAS_LAT-1];
endmodule : sdcs_mem
`default_nettype wire

// *** sdcs_pkg.sv ***
// package for the sdram command state machine: commands, states and timing counts
`default_nettype none
package sdcs_pkg;
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned NUM_BANKS = 4;
    localparam int unsigned BANK_W = 2;
    localparam int unsigned ADDR_W = 13;
    localparam int unsigned AP_BIT = 10;
    localparam int unsigned COL_W = 10;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W = 8;
    localparam int unsigned T_RCD_NS = 20;
    localparam int unsigned T_RP_NS = 20;
    localparam int unsigned T_RPL_NS = 35;
    localparam int unsigned T_RFC_NS = 70;
    localparam logic [CNT_W-1:0] RCD_CYC =
        CNT_W'((T_RCD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RP_CYC =
        CNT_W'((T_RP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RPL_CYC =
        CNT_W'((T_RPL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] RFC_CYC =
        CNT_W'((T_RFC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] MRS_CYC = 8'h02;
    localparam logic [CNT_W-1:0] BURST_LEN = 8'h04;
    localparam logic [2:0] CAS_LAT = 3'h2;
    // command encodings {cs_n, ras_n, cas_n, we_n}
    localparam logic [3:0] CMD_NOP = 4'h7;
    localparam logic [3:0] CMD_STOP = 4'h6;
    localparam logic [3:0] CMD_READ = 4'h5;
    localparam logic [3:0] CMD_WRITE = 4'h4;
    localparam logic [3:0] CMD_ACT = 4'h3;
    localparam logic [3:0] CMD_PRE = 4'h2;
    localparam logic [3:0] CMD_REF = 4'h1;
    localparam logic [3:0] CMD_MRS = 4'h0;
    typedef enum logic [3:0] {
        SDCS_IDLE, SDCS_ACTIVATING, SDCS_ACTIVE, SDCS_READ, SDCS_WRITE,
        SDCS_READ_AP, SDCS_WRITE_AP, SDCS_PRECHARGING
    } sdcs_bank_e;
    typedef enum logic [2:0] {
        SDCS_DEV_NORMAL, SDCS_DEV_REFRESH, SDCS_DEV_MODE, SDCS_DEV_SELF,
        SDCS_DEV_POWERDOWN, SDCS_DEV_SUSPEND
    } sdcs_dev_e;
endpackage : sdcs_pkg
`default_nettype wire

// *** sdram_command_state_machine_bench.sv ***
// self-checking bench: issuer and memory ends joined by the interface
`default_nettype none
module sdram_command_state_machine_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [3:0] cmd;
        logic [1:0] ba;
        logic [12:0] addr;
        logic [3:0] act;
        logic [7:0] rd;
        logic [7:0] wr;
    } sdcs_row_s;
    logic i_clock = 1'b0;
    logic i_resetn = 1'b0;
    logic clk_en = 1'b1;
    logic req_valid = 1'b0;
    logic [3:0] req_cmd = sdcs_pkg::CMD_NOP;
    logic req_cke = 1'b1;
    logic [1:0] req_ba = 2'h0;
    logic [12:0] req_addr = 13'h0000;
    logic [15:0] req_wdata = 16'h5a5a;
    logic req_ready, rdata_valid, all_idle, self_ref, pdown, suspend, illegal, wstrobe;
    logic [3:0] bank_active;
    logic [7:0] rd_beats = 8'h00;
    logic [7:0] wr_beats = 8'h00;
    logic [7:0] ill_cnt = 8'h00;
    logic [7:0] snap;
    logic [15:0] wdata_seen;
    int checked = 0;
    int fail_count = 0;
    sdcs_row_s rows [10] = '{
        '{sdcs_pkg::CMD_ACT, 2'h0, 13'h0123, 4'h1, 8'h00, 8'h00},
        '{sdcs_pkg::CMD_ACT, 2'h2, 13'h0045, 4'h5, 8'h00, 8'h00},
        '{sdcs_pkg::CMD_WRITE, 2'h0, 13'h0005, 4'h5, 8'h00, 8'h04},
        '{sdcs_pkg::CMD_READ, 2'h2, 13'h0408, 4'h1, 8'h04, 8'h04},
        '{sdcs_pkg::CMD_READ, 2'h0, 13'h0008, 4'h1, 8'h08, 8'h04},
        '{sdcs_pkg::CMD_WRITE, 2'h0, 13'h0400, 4'h0, 8'h08, 8'h08},
        '{sdcs_pkg::CMD_REF, 2'h0, 13'h0000, 4'h0, 8'h08, 8'h08},
        '{sdcs_pkg::CMD_MRS, 2'h0, 13'h0022, 4'h0, 8'h08, 8'h08},
        '{sdcs_pkg::CMD_ACT, 2'h1, 13'h0077, 4'h2, 8'h08, 8'h08},
        '{sdcs_pkg::CMD_PRE, 2'h1, 13'h0000, 4'h0, 8'h08, 8'h08}
    };
    sdcs_if bus_if ();
    sdcs_ctl u_sdcs_ctl (.i_clock(i_clock), .i_resetn(i_resetn), .i_clk_en(clk_en),
        .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_cmd(req_cmd),
        .i_req_cke(req_cke), .i_req_ba(req_ba), .i_req_addr(req_addr),
        .i_req_wdata(req_wdata), .o_rdata(), .o_rdata_valid(rdata_valid), .bus(bus_if));
    sdcs_mem u_sdcs_mem (.i_clock(i_clock), .i_resetn(i_resetn), .i_clk_en(clk_en),
        .o_bank_active(bank_active), .o_all_idle(all_idle), .o_self_refresh(self_ref),
        .o_power_down(pdown), .o_suspend(suspend), .o_illegal(illegal),
        .o_write_strobe(wstrobe), .o_write_bank(), .o_write_col(), .o_write_data(wdata_seen),
        .bus(bus_if));
    sdcs_chk u_sdcs_chk (.i_clock(i_clock), .i_resetn(i_resetn), .cke(bus_if.cke),
        .cs_n(bus_if.cs_n), .ras_n(bus_if.ras_n), .cas_n(bus_if.cas_n),
        .we_n(bus_if.we_n), .dq_oe(bus_if.dq_oe));
    always #12.5 i_clock = ~i_clock;
    always @(posedge i_clock) begin
        if (rdata_valid === 1'b1) rd_beats <= rd_beats + 8'h01;
        if (wstrobe === 1'b1) wr_beats <= wr_beats + 8'h01;
        if (illegal === 1'b1) ill_cnt <= ill_cnt + 8'h01;
    end
    task automatic settle(input int n);
        repeat (n) @(negedge i_clock);
    endtask : settle
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        checked++;
        if (got !== exp) begin
            $display("unexpected %s expected %h seen %h", name, exp, got);
            fail_count++;
        end
    endtask : chk
    // holds the request from a falling edge until the edge that takes it
    task automatic issue(input logic [3:0] cmd, input logic cke, input logic [1:0] ba,
            input logic [12:0] addr);
        int n;
        n = 0;
        @(negedge i_clock);
        req_valid = 1'b1;
        req_cmd = cmd;
        req_cke = cke;
        req_ba = ba;
        req_addr = addr;
        while (req_ready !== 1'b1 && n < 64) begin
            @(negedge i_clock);
            n++;
        end
        if (n == 64) fail_count++;
        @(negedge i_clock);
        req_valid = 1'b0;
        req_cmd = sdcs_pkg::CMD_NOP;
    endtask : issue
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : wrap_up
    initial begin
        settle(20);
        i_resetn = 1'b1;
        chk("all_idle", 8'h01, 8'(all_idle));
        foreach (rows[i]) begin
            issue(rows[i].cmd, 1'b1, rows[i].ba, rows[i].addr);
            settle(12);
            chk("bank_active", 8'(rows[i].act), 8'(bank_active));
            chk("all_idle", 8'(rows[i].act == 4'h0), 8'(all_idle));
            chk("read_beats", rows[i].rd, rd_beats);
            chk("write_beats", rows[i].wr, wr_beats);
            $display("row %0d done", i);
        end
        chk("write_data", 8'h5a, wdata_seen[7:0]);
        issue(sdcs_pkg::CMD_REF, 1'b0, 2'h0, 13'h0000);
        settle(4);
        chk("self_refresh", 8'h01, 8'(self_ref));
        issue(sdcs_pkg::CMD_NOP, 1'b1, 2'h0, 13'h0000);
        settle(8);
        chk("self_refresh", 8'h00, 8'(self_ref));
        chk("all_idle", 8'h01, 8'(all_idle));
        issue(sdcs_pkg::CMD_NOP, 1'b0, 2'h0, 13'h0000);
        settle(4);
        chk("power_down", 8'h01, 8'(pdown));
        issue(sdcs_pkg::CMD_NOP, 1'b1, 2'h0, 13'h0000);
        settle(4);
        chk("power_down", 8'h00, 8'(pdown));
        $display("low power test done");
        issue(sdcs_pkg::CMD_ACT, 1'b1, 2'h3, 13'h0011);
        settle(4);
        issue(sdcs_pkg::CMD_NOP, 1'b0, 2'h0, 13'h0000);
        settle(4);
        chk("suspend", 8'h01, 8'(suspend));
        issue(sdcs_pkg::CMD_NOP, 1'b1, 2'h0, 13'h0000);
        settle(4);
        chk("suspend", 8'h00, 8'(suspend));
        snap = ill_cnt;
        issue(sdcs_pkg::CMD_REF, 1'b1, 2'h0, 13'h0000);
        settle(6);
        chk("bank_active", 8'h08, 8'(bank_active));
        chk("illegal", 8'h01, 8'(ill_cnt != snap));
        snap = ill_cnt;
        issue(sdcs_pkg::CMD_ACT, 1'b1, 2'h3, 13'h0011);
        settle(2);
        chk("illegal", 8'h01, 8'(ill_cnt != snap));
        chk("bank_active", 8'h08, 8'(bank_active));
        issue(sdcs_pkg::CMD_PRE, 1'b1, 2'h0, 13'h0400);
        settle(6);
        chk("bank_active", 8'h00, 8'(bank_active));
        $display("suspend test done");
        issue(sdcs_pkg::CMD_ACT, 1'b1, 2'h1, 13'h0033);
        settle(3);
        i_resetn = 1'b0;
        settle(2);
        chk("bank_active", 8'h00, 8'(bank_active));
        i_resetn = 1'b1;
        settle(4);
        $display("reset test done");
        wrap_up();
    end
    // the tests need a few hundred clocks; this limit leaves wide margin
    initial begin
        repeat (5000) @(posedge i_clock);
        fail_count++;
        wrap_up();
    end
endmodule : sdram_command_state_machine_bench
`default_nettype wire
